// *** pkg/swrb_pkg.sv ***
// swrb_pkg: constants shared by the single-wire reset and bit slot block
package swrb_pkg;

    // ------------------------------------------------------------------
    // clock and timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_PS = 10000;
    localparam int ACT_MAX_PS    = 262500;
    // longest time: round down
    localparam int ACT_MAX_CYC   = ACT_MAX_PS / CLK_PERIOD_PS;

    // line times in ns, standard speed
    localparam int RSTL_NS = 600000;
    localparam int RSTH_NS = 600000;
    localparam int SI_NS   = 8000;
    localparam int MSP_NS  = 70000;
    localparam int SLOT_NS = 70000;
    localparam int MSR_NS  = 15000;
    localparam int LOW0_NS = 60000;
    localparam int LOW1_NS = 8000;

    // least times: round up to whole cycles
    localparam int CLK_NS   = CLK_PERIOD_PS / 1000;
    localparam int CYC_RSTL = (RSTL_NS + CLK_NS - 1) / CLK_NS;
    localparam int CYC_RSTH = (RSTH_NS + CLK_NS - 1) / CLK_NS;
    localparam int CYC_SI   = (SI_NS + CLK_NS - 1) / CLK_NS;
    localparam int CYC_MSP  = (MSP_NS + CLK_NS - 1) / CLK_NS;
    localparam int CYC_SLOT = (SLOT_NS + CLK_NS - 1) / CLK_NS;
    localparam int CYC_MSR  = (MSR_NS + CLK_NS - 1) / CLK_NS;
    localparam int CYC_LOW0 = (LOW0_NS + CLK_NS - 1) / CLK_NS;
    localparam int CYC_LOW1 = (LOW1_NS + CLK_NS - 1) / CLK_NS;
    // overdrive shortens every time by this factor
    localparam int OD_DIV   = 8;
    localparam int CNT_W    = 20;

    // ------------------------------------------------------------------
    // command codes
    // ------------------------------------------------------------------
    localparam logic [7:0] CMD_DEV_RESET  = 8'hf0;
    localparam logic [7:0] CMD_LINE_RESET = 8'hb4;
    localparam logic [7:0] CMD_SINGLE_BIT = 8'h87;
    localparam logic [7:0] PTR_STATUS     = 8'hf0;
    localparam logic [7:0] PTR_CONFIG     = 8'hc3;
    localparam int         BIT_VAL_POS    = 7;

    // ------------------------------------------------------------------
    // register map (word index = byte address bits 4:2)
    // ------------------------------------------------------------------
    localparam logic [2:0] IDX_CMD    = 3'h0;
    localparam logic [2:0] IDX_STATUS = 3'h1;
    localparam logic [2:0] IDX_CONFIG = 3'h2;
    localparam logic [2:0] IDX_PTR    = 3'h3;
    localparam logic [2:0] IDX_RDATA  = 3'h4;

    // status bits
    localparam int ST_BUSY    = 0;
    localparam int ST_PPD     = 1;
    localparam int ST_SD      = 2;
    localparam int ST_DEV_RST = 3;
    localparam int ST_REFUSED = 4;
    localparam int ST_SBR     = 5;
    // config bits (low nibble)
    localparam int CF_APU = 0;
    localparam int CF_SPU = 2;
    localparam int CF_ODS = 3;

    typedef enum logic [1:0] {OP_IDLE, OP_RESET, OP_SLOT} swrb_op_t;

endpackage : swrb_pkg

// *** design/swrb_sync.sv ***
// swrb_sync: three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module swrb_sync
(
    // clock and reset
    input  wire logic clk_in,
    input  wire logic rst_n_in,
    // asynchronous level in, filtered level out
    input  wire logic async_in,
    output logic      level_out
);
    logic meta_r;
    logic s2_r;
    logic s3_r;
    logic level_r;
    logic level_nxt;

    // idle line floats high through the pullup
    always_comb
    begin
        level_nxt = (s2_r == s3_r) ? s3_r : level_r;
    end

    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            meta_r  <= 1'b1;
            s2_r    <= 1'b1;
            s3_r    <= 1'b1;
            level_r <= 1'b1;
        end
        else
        begin
            meta_r  <= async_in;
            s2_r    <= meta_r;
            s3_r    <= s2_r;
            level_r <= level_nxt;
        end
    end

    assign level_out = level_r;

endmodule : swrb_sync

// *** design/swrb_top.sv ***
// swrb_top: single-wire reset cycle and single bit slot engine
//
// Functional notes
// RULE1 - reset command starts one reset/presence cycle
// RULE2 - reset refused and ignored while line busy
// RULE3 - reset drives line promptly, ends on time
// RULE4 - sample line for short and presence
// RULE5 - busy span, presence and short update times
// RULE6 - accepted reset points reads at status
// RULE7 - host brackets sequences with reset cycles
// RULE8 - bit command makes exactly one slot
// RULE9 - slot value in parameter bit seven
// RULE10 - zero writes zero, one writes/reads
// RULE11 - sample line at bit sample time
// RULE12 - bit command refused while line busy
// RULE13 - slot drives promptly, ends on time
// RULE14 - busy held for one slot time
// RULE15 - accepted slot points reads at status
// RULE16 - slot uses speed and pullup settings
// RULE17 - device reset aborts line activity
// RULE18 - busy clears when activity completes
`timescale 1ns/1ps
module swrb_top
    import swrb_pkg::*;
#(
    parameter int RSTL_CYC = CYC_RSTL,
    parameter int RSTH_CYC = CYC_RSTH,
    parameter int MSP_CYC  = CYC_MSP,
    parameter int SLOT_CYC = CYC_SLOT,
    parameter int LOW0_CYC = CYC_LOW0
)
(
    // clock and reset
    input  wire logic        clk_in,
    input  wire logic        rst_n_in,
    // wishbone slave
    input  wire logic        wb_cyc_in,
    input  wire logic        wb_stb_in,
    input  wire logic        wb_we_in,
    input  wire logic [4:0]  wb_adr_in,
    input  wire logic [3:0]  wb_sel_in,
    input  wire logic [31:0] wb_dat_in,
    output logic      [31:0] wb_dat_out,
    output logic             wb_ack_out,
    // single-wire line, open drain
    input  wire logic        line_in,
    output logic             line_out,
    output logic             line_oe_out,
    // pullup controls
    output logic             active_pullup_out,
    output logic             strong_pullup_out
);

    // ------------------------------------------------------------------
    // line input and speed-dependent counts
    // ------------------------------------------------------------------
    localparam int START_MAX = ACT_MAX_CYC;

    logic line_lvl;

    swrb_sync u_sync
    (
        .clk_in    (clk_in),
        .rst_n_in  (rst_n_in),
        .async_in  (line_in),
        .level_out (line_lvl)
    );

    logic             cfg_ods_r;
    logic             cfg_apu_r;
    logic             cfg_spu_r;
    logic [CNT_W-1:0] t_rstl;
    logic [CNT_W-1:0] t_sd_at;
    logic [CNT_W-1:0] t_ppd_at;
    logic [CNT_W-1:0] t_rst_end;
    logic [CNT_W-1:0] t_slot;
    logic [CNT_W-1:0] t_msr;
    logic [CNT_W-1:0] t_low0;
    logic [CNT_W-1:0] t_low1;

    // RULE16 speed select
    always_comb
    begin
        if (cfg_ods_r)
        begin
            t_rstl    = CNT_W'(RSTL_CYC / OD_DIV);
            t_sd_at   = CNT_W'((RSTL_CYC + CYC_SI) / OD_DIV);
            t_ppd_at  = CNT_W'((RSTL_CYC + MSP_CYC) / OD_DIV);
            t_rst_end = CNT_W'((RSTL_CYC + RSTH_CYC) / OD_DIV);
            t_slot    = CNT_W'(SLOT_CYC / OD_DIV);
            t_msr     = CNT_W'(CYC_MSR / OD_DIV);
            t_low0    = CNT_W'(LOW0_CYC / OD_DIV);
            t_low1    = CNT_W'(CYC_LOW1 / OD_DIV);
        end
        else
        begin
            t_rstl    = CNT_W'(RSTL_CYC);
            t_sd_at   = CNT_W'(RSTL_CYC + CYC_SI);
            t_ppd_at  = CNT_W'(RSTL_CYC + MSP_CYC);
            t_rst_end = CNT_W'(RSTL_CYC + RSTH_CYC);
            t_slot    = CNT_W'(SLOT_CYC);
            t_msr     = CNT_W'(CYC_MSR);
            t_low0    = CNT_W'(LOW0_CYC);
            t_low1    = CNT_W'(CYC_LOW1);
        end
    end

    // ------------------------------------------------------------------
    // wishbone handshake
    // ------------------------------------------------------------------
    logic        ack_r;
    logic        ack_nxt;
    logic [31:0] dat_r;
    logic [31:0] dat_nxt;
    logic        take;
    logic [2:0]  idx;
    logic [7:0]  status_byte;
    logic [7:0]  config_byte;
    logic [7:0]  ptr_r;

    assign idx  = wb_adr_in[4:2];
    // a write lands at the edge where the master sees ack
    assign take = wb_cyc_in && wb_stb_in && ack_r;

    always_comb
    begin
        ack_nxt = wb_cyc_in && wb_stb_in && !ack_r;
        dat_nxt = dat_r;
        if (ack_nxt && !wb_we_in)
        begin
            unique case (idx)
                IDX_STATUS: dat_nxt = {24'h00_0000, status_byte};
                IDX_CONFIG: dat_nxt = {24'h00_0000, config_byte};
                IDX_PTR:    dat_nxt = {24'h00_0000, ptr_r};
                IDX_RDATA:  dat_nxt = (ptr_r == PTR_CONFIG) ?
                                      {24'h00_0000, config_byte} :
                                      {24'h00_0000, status_byte};
                default:    dat_nxt = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            ack_r <= 1'b0;
            dat_r <= 32'h0000_0000;
        end
        else
        begin
            ack_r <= ack_nxt;
            dat_r <= dat_nxt;
        end
    end

    assign wb_ack_out = ack_r;
    assign wb_dat_out = dat_r;

    // ------------------------------------------------------------------
    // command engine
    // ------------------------------------------------------------------
    swrb_op_t         op_r;
    swrb_op_t         op_nxt;
    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] cnt_nxt;
    logic             bit_r;
    logic             bit_nxt;
    logic             ppd_r;
    logic             ppd_nxt;
    logic             sd_r;
    logic             sd_nxt;
    logic             sbr_r;
    logic             sbr_nxt;
    logic             devrst_r;
    logic             devrst_nxt;
    logic             refused_r;
    logic             refused_nxt;
    logic [7:0]       ptr_nxt;
    logic             cfg_ods_nxt;
    logic             cfg_apu_nxt;
    logic             cfg_spu_nxt;
    logic             oe_r;
    logic             oe_nxt;
    logic             apu_r;
    logic             apu_nxt;
    logic             spu_on_r;
    logic             spu_on_nxt;
    logic             busy;
    logic             cmd_wr;
    logic [7:0]       code;
    logic [7:0]       param;
    logic             line_cmd;
    logic             start;
    logic [CNT_W-1:0] t_end;
    logic [3:0]       cf_lo;

    assign busy     = (op_r != OP_IDLE);
    assign cmd_wr   = take && wb_we_in && (idx == IDX_CMD) && wb_sel_in[0];
    assign code     = wb_dat_in[7:0];
    // parameter byte only counts when its lane is enabled
    assign param    = wb_sel_in[1] ? wb_dat_in[15:8] : 8'h00;
    assign line_cmd = (code == CMD_LINE_RESET) || (code == CMD_SINGLE_BIT);
    // RULE2 RULE12 busy refusal
    assign start    = cmd_wr && line_cmd && !busy;
    assign t_end    = (op_r == OP_RESET) ? t_rst_end : t_slot;
    assign cf_lo    = wb_dat_in[3:0];

    assign status_byte = {2'b00, sbr_r, refused_r, devrst_r,
                          sd_r, ppd_r, busy};
    assign config_byte = {4'h0, cfg_ods_r, cfg_spu_r, 1'b0, cfg_apu_r};

    always_comb
    begin
        op_nxt      = op_r;
        cnt_nxt     = cnt_r + CNT_W'(1);
        bit_nxt     = bit_r;
        ppd_nxt     = ppd_r;
        sd_nxt      = sd_r;
        sbr_nxt     = sbr_r;
        devrst_nxt  = devrst_r;
        refused_nxt = refused_r;
        ptr_nxt     = ptr_r;
        cfg_ods_nxt = cfg_ods_r;
        cfg_apu_nxt = cfg_apu_r;
        cfg_spu_nxt = cfg_spu_r;
        spu_on_nxt  = spu_on_r;
        oe_nxt      = 1'b0;

        // RULE4 sample short
        if (op_r == OP_RESET && cnt_r == t_sd_at)
            sd_nxt = !line_lvl;
        // RULE5 presence update
        if (op_r == OP_RESET && cnt_r == t_ppd_at)
            ppd_nxt = !line_lvl;
        // RULE11 sample bit
        if (op_r == OP_SLOT && cnt_r == t_msr)
            sbr_nxt = line_lvl;
        // RULE18 end of activity
        if (busy && cnt_r == t_end - CNT_W'(1))
        begin
            op_nxt = OP_IDLE;
            // RULE16 strong pullup after the slot
            if (op_r == OP_SLOT && cfg_spu_r)
                spu_on_nxt = 1'b1;
        end

        if (cmd_wr && code == CMD_DEV_RESET)
        begin
            // RULE17 abort and clear
            op_nxt      = OP_IDLE;
            ppd_nxt     = 1'b0;
            sd_nxt      = 1'b0;
            sbr_nxt     = 1'b0;
            refused_nxt = 1'b0;
            devrst_nxt  = 1'b1;
            cfg_ods_nxt = 1'b0;
            cfg_apu_nxt = 1'b0;
            cfg_spu_nxt = 1'b0;
            spu_on_nxt  = 1'b0;
            ptr_nxt     = PTR_STATUS;
        end
        else if (cmd_wr && line_cmd && busy)
            refused_nxt = 1'b1;
        else if (start)
        begin
            // RULE1 RULE8 launch one cycle or slot
            cnt_nxt     = '0;
            refused_nxt = 1'b0;
            spu_on_nxt  = 1'b0;
            op_nxt      = (code == CMD_LINE_RESET) ? OP_RESET : OP_SLOT;
            // RULE9 RULE10 slot value from bit seven
            bit_nxt     = param[BIT_VAL_POS];
            // RULE6 RULE15 point reads at status
            ptr_nxt     = PTR_STATUS;
        end
        else if (take && wb_we_in && wb_sel_in[0] && !busy &&
                 idx == IDX_CONFIG && wb_dat_in[7:4] == ~cf_lo)
        begin
            // config writes take effect only while the line is quiet
            cfg_apu_nxt = cf_lo[CF_APU];
            cfg_spu_nxt = cf_lo[CF_SPU];
            cfg_ods_nxt = cf_lo[CF_ODS];
            devrst_nxt  = 1'b0;
            spu_on_nxt  = 1'b0;
            ptr_nxt     = PTR_CONFIG;
        end
        else if (take && wb_we_in && wb_sel_in[0] && idx == IDX_PTR &&
                 (code == PTR_STATUS || code == PTR_CONFIG))
            ptr_nxt = code;

        // RULE3 RULE13 drive low right after launch
        unique case (op_nxt)
            OP_RESET: oe_nxt = (cnt_nxt < t_rstl);
            OP_SLOT:  oe_nxt = (cnt_nxt < (bit_nxt ? t_low1 : t_low0));
            OP_IDLE:  oe_nxt = 1'b0;
        endcase
        // RULE16 active pullup whenever the line is released during activity
        apu_nxt = cfg_apu_r && (op_nxt != OP_IDLE) && !oe_nxt;
    end

    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            op_r      <= OP_IDLE;
            cnt_r     <= '0;
            bit_r     <= 1'b0;
            ppd_r     <= 1'b0;
            sd_r      <= 1'b0;
            sbr_r     <= 1'b0;
            devrst_r  <= 1'b1;
            refused_r <= 1'b0;
            ptr_r     <= PTR_STATUS;
            cfg_ods_r <= 1'b0;
            cfg_apu_r <= 1'b0;
            cfg_spu_r <= 1'b0;
            oe_r      <= 1'b0;
            apu_r     <= 1'b0;
            spu_on_r  <= 1'b0;
        end
        else
        begin
            op_r      <= op_nxt;
            cnt_r     <= cnt_nxt;
            bit_r     <= bit_nxt;
            ppd_r     <= ppd_nxt;
            sd_r      <= sd_nxt;
            sbr_r     <= sbr_nxt;
            devrst_r  <= devrst_nxt;
            refused_r <= refused_nxt;
            ptr_r     <= ptr_nxt;
            cfg_ods_r <= cfg_ods_nxt;
            cfg_apu_r <= cfg_apu_nxt;
            cfg_spu_r <= cfg_spu_nxt;
            oe_r      <= oe_nxt;
            apu_r     <= apu_nxt;
            spu_on_r  <= spu_on_nxt;
        end
    end

    assign line_out          = 1'b0;
    assign line_oe_out       = oe_r;
    assign active_pullup_out = apu_r;
    assign strong_pullup_out = spu_on_r;

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);

    // RULE3 prompt drive
    a_start_drive: assert property (start |-> ##[1:START_MAX] line_oe_out)
        else $error("line not driven after launch");
    // RULE2 refusal
    a_refuse_busy: assert property (
        (cmd_wr && line_cmd && busy) |=> refused_r && !$past(start))
        else $error("busy line command not refused");
    // RULE14 busy span
    a_busy_hold: assert property (
        (busy && cnt_r < t_end - CNT_W'(1) && !(cmd_wr &&
         code == CMD_DEV_RESET)) |=> (op_r == $past(op_r)))
        else $error("busy dropped early");
    // RULE18 busy clear
    a_busy_clear: assert property (
        (busy && cnt_r == t_end - CNT_W'(1) && !start) |=> !busy)
        else $error("busy not cleared at end");
    // RULE4 short sample
    a_sd_sample: assert property (
        (op_r == OP_RESET && cnt_r == t_sd_at && !cmd_wr)
        |=> sd_r == !$past(line_lvl))
        else $error("short flag not sampled");
    // RULE5 presence sample
    a_ppd_sample: assert property (
        (op_r == OP_RESET && cnt_r == t_ppd_at && !cmd_wr)
        |=> ppd_r == !$past(line_lvl))
        else $error("presence flag not sampled");
    // RULE11 bit sample
    a_sbr_sample: assert property (
        (op_r == OP_SLOT && cnt_r == t_msr && !cmd_wr)
        |=> sbr_r == $past(line_lvl))
        else $error("bit result not sampled");
    // RULE6 pointer to status
    a_ptr_status: assert property (start |=> ptr_r == PTR_STATUS)
        else $error("pointer not at status");
    // RULE17 abort
    a_abort_line: assert property (
        (cmd_wr && code == CMD_DEV_RESET) |=> !busy && !line_oe_out)
        else $error("device reset left line active");
    // RULE10 zero slot stays low longer than a one slot
    a_slot_low: assert property (
        (op_r == OP_SLOT && cnt_r == t_low1 && !bit_r &&
         t_low1 < t_low0) |-> line_oe_out)
        else $error("zero slot released early");

endmodule : swrb_top

// *** dv/swrb_slave_model.sv ***
// swrb_slave_model: behavioural single-wire slave for the bench
`timescale 1ns/1ps
module swrb_slave_model
(
    // clock
    input  wire logic clk_in,
    // wire level and behaviour controls
    input  wire logic line_in,
    input  wire logic presence_en_in,
    input  wire logic short_en_in,
    input  wire logic read_bit_in,
    input  wire logic slow_in,
    // pull low request
    output logic      pull_out
);
    // ------------------------------------------------------------------
    // timing in clock cycles
    // ------------------------------------------------------------------
    // a low of at least this many cycles is taken as a reset pulse
    localparam int RST_MIN  = 230;
    // presence must end before the master's reset span does
    localparam int PRES_LEN = 100;
    // zero reply outlasts the sample point but not the slot
    localparam int ZERO_LEN = 210;
    int   low_cnt  = 0;
    int   wait_cnt = 0;
    int   pres_cnt = 0;
    int   zero_cnt = 0;
    logic line_q   = 1'b1;

    // ------------------------------------------------------------------
    // reply logic
    // ------------------------------------------------------------------
    always @(posedge clk_in)
    begin
        low_cnt <= line_in ? 0 : low_cnt + 1;
        line_q  <= line_in;
        // own pull must not look like a master slot
        if (line_q && !line_in && !pull_out && !read_bit_in)
            zero_cnt <= ZERO_LEN;
        else if (zero_cnt > 0)
            zero_cnt <= zero_cnt - 1;
        if (!line_q && line_in && low_cnt >= RST_MIN && presence_en_in)
            // wait past the short sample point, else it reads as a short
            wait_cnt <= slow_in ? 140 : 110;
        else if (wait_cnt > 0)
            wait_cnt <= wait_cnt - 1;
        if (wait_cnt == 1)
            pres_cnt <= PRES_LEN;
        else if (pres_cnt > 0)
            pres_cnt <= pres_cnt - 1;
    end
    assign pull_out = short_en_in || zero_cnt > 0 || pres_cnt > 0;
endmodule : swrb_slave_model

// *** dv/swrb_top_tb.sv ***
// swrb_top_tb: self-checking bench for the reset and bit slot engine
`timescale 1ns/1ps
`define CHECK(got, exp) \
    begin comparisons++; if ((got) !== (exp)) begin failures++; \
    $display("[FAIL] %0t got %0h exp %0h", $time, got, exp); end end
module swrb_top_tb
    import swrb_pkg::*;
;
    // ------------------------------------------------------------------
    // setup: short counts, overdrive divides them further
    // ------------------------------------------------------------------
    localparam int RSTL    = 2000;
    localparam int SLOT    = 2400;
    localparam int LOW0    = 1600;
    localparam int T_SPAN  = 2 * RSTL / OD_DIV;
    localparam int T_LOW   = RSTL / OD_DIV;
    localparam int T_SLOT  = SLOT / OD_DIV;
    localparam int T_LOW0  = LOW0 / OD_DIV;
    localparam int T_LOW1  = CYC_LOW1 / OD_DIV;
    localparam int TIMEOUT = 20000;
    logic        clk_in = 1'b0;
    logic        rst_n_in = 1'b0;
    logic        wb_cyc_in = 1'b0;
    logic        wb_stb_in = 1'b0;
    logic        wb_we_in = 1'b0;
    logic [4:0]  wb_adr_in = 5'h00;
    logic [31:0] wb_dat_in = 32'h0;
    logic [3:0]  wb_sel_in = 4'h0;
    logic [31:0] wb_dat_out;
    logic        wb_ack_out;
    logic        line_oe_out;
    logic        active_pullup_out;
    logic        strong_pullup_out;
    logic        pull;
    logic        line_w;
    logic        pres_en = 1'b1;
    logic        short_en = 1'b0;
    logic        rbit = 1'b1;
    logic        slow = 1'b0;
    logic        oe_q = 1'b0;
    logic        apu_seen = 1'b0;
    logic [31:0] rd;
    int          failures = 0;
    int          comparisons = 0;
    int          cyc = 0;
    int          launch = 0;
    int          oe_start = 0;
    int          oe_len = 0;
    int          pulses = 0;

    // released wire is held high by its pull-up
    assign line_w = !(line_oe_out || pull);

    swrb_top #(.RSTL_CYC(RSTL), .RSTH_CYC(RSTL), .MSP_CYC(1600),
               .SLOT_CYC(SLOT), .LOW0_CYC(LOW0)) dut
    (
        .clk_in(clk_in), .rst_n_in(rst_n_in), .wb_cyc_in(wb_cyc_in),
        .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in),
        .wb_sel_in(wb_sel_in), .wb_dat_in(wb_dat_in), .wb_dat_out(wb_dat_out),
        .wb_ack_out(wb_ack_out), .line_in(line_w), .line_out(),
        .line_oe_out(line_oe_out), .active_pullup_out(active_pullup_out),
        .strong_pullup_out(strong_pullup_out)
    );

    swrb_slave_model slave
    (
        .clk_in(clk_in), .line_in(line_w), .presence_en_in(pres_en),
        .short_en_in(short_en), .read_bit_in(rbit), .slow_in(slow),
        .pull_out(pull)
    );

    initial
    begin
        forever #5 clk_in = ~clk_in;
    end

    // ------------------------------------------------------------------
    // monitor and timeout
    // ------------------------------------------------------------------
    always @(posedge clk_in)
    begin
        cyc  <= cyc + 1;
        oe_q <= line_oe_out;
        if (line_oe_out && !oe_q)
            oe_start <= cyc;
        if (!line_oe_out && oe_q)
        begin
            oe_len <= cyc - oe_start;
            pulses <= pulses + 1;
        end
        if (active_pullup_out)
            apu_seen <= 1'b1;
        if (cyc >= TIMEOUT)
        begin
            failures++;
            report_and_stop();
        end
    end

    task automatic report_and_stop();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : report_and_stop

    task automatic wb(input logic we, input logic [4:0] adr,
                      input logic [31:0] dat);
        @(posedge clk_in);
        wb_cyc_in <= 1'b1;
        wb_stb_in <= 1'b1;
        wb_we_in  <= we;
        wb_adr_in <= adr;
        wb_sel_in <= 4'hf;
        wb_dat_in <= dat;
        do @(posedge clk_in); while (wb_ack_out !== 1'b1);
        rd = wb_dat_out;
        launch = cyc;
        wb_cyc_in <= 1'b0;
        wb_stb_in <= 1'b0;
        wb_sel_in <= 4'h0;
    endtask : wb

    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task automatic line_cmd(input logic [15:0] cmd, input int low,
                            input int busy, input logic [5:0] msk,
                            input logic [5:0] exp);
        int t0;
        int np;
        np = pulses;
        wb(1'b1, 5'h0c, 32'hc3);
        wb(1'b1, 5'h00, {16'h0, cmd});
        t0 = launch;
        wb(1'b0, 5'h10, 32'h0);
        `CHECK(rd[ST_BUSY], 1'b1)
        // same command again while busy must be refused and ignored
        wb(1'b1, 5'h00, {16'h0, cmd});
        do wb(1'b0, 5'h04, 32'h0); while (rd[ST_BUSY] !== 1'b0);
        `CHECK(cyc-t0 >= busy && cyc-t0 <= busy+ACT_MAX_CYC, 1'b1)
        `CHECK(oe_start - t0 <= ACT_MAX_CYC, 1'b1)
        `CHECK(oe_len, low)
        `CHECK(pulses - np, 1)
        `CHECK(rd[5:0] & msk, exp)
        `CHECK(rd[ST_REFUSED], 1'b1)
        $display("line command %h done", cmd);
    endtask : line_cmd

    task automatic t_pullup();
        `CHECK(apu_seen, 1'b0)
        wb(1'b1, 5'h08, 32'h2d);
        line_cmd(16'hd587, T_LOW1, T_SLOT, 6'h20, 6'h20);
        `CHECK(apu_seen, 1'b1)
        `CHECK(strong_pullup_out, 1'b1)
        wb(1'b1, 5'h08, 32'h78);
        repeat (2) @(posedge clk_in);
        `CHECK(strong_pullup_out, 1'b0)
        $display("pullup test done");
    endtask : t_pullup

    task automatic t_abort();
        wb(1'b1, 5'h00, 32'hb4);
        repeat (20) @(posedge clk_in);
        wb(1'b1, 5'h00, 32'hf0);
        repeat (ACT_MAX_CYC) @(posedge clk_in);
        `CHECK(line_oe_out, 1'b0)
        wb(1'b0, 5'h04, 32'h0);
        `CHECK(rd[3:0], 4'h8)
        wb(1'b1, 5'h08, 32'h78);
        $display("abort test done");
    endtask : t_abort

    initial
    begin
        repeat (16) @(posedge clk_in);
        rst_n_in <= 1'b1;
        wb(1'b0, 5'h04, 32'h0);
        `CHECK(rd, 32'h8)
        wb(1'b0, 5'h14, 32'h0);
        `CHECK(rd, 32'h0)
        wb(1'b1, 5'h08, 32'h78);
        line_cmd(16'h00b4, T_LOW, T_SPAN, 6'h06, 6'h02);
        pres_en <= 1'b0;
        line_cmd(16'h00b4, T_LOW, T_SPAN, 6'h06, 6'h00);
        short_en <= 1'b1;
        pres_en <= 1'b1;
        line_cmd(16'h00b4, T_LOW, T_SPAN, 6'h06, 6'h06);
        // no presence answer to the release of the short
        short_en <= 1'b0;
        pres_en <= 1'b0;
        // value in bit 7, junk below
        line_cmd(16'hd587, T_LOW1, T_SLOT, 6'h20, 6'h20);
        rbit <= 1'b0;
        line_cmd(16'hd587, T_LOW1, T_SLOT, 6'h20, 6'h00);
        rbit <= 1'b1;
        line_cmd(16'h7f87, T_LOW0, T_SLOT, 6'h20, 6'h00);
        t_pullup();
        t_abort();
        slow <= 1'b1;
        pres_en <= 1'b1;
        line_cmd(16'h00b4, T_LOW, T_SPAN, 6'h06, 6'h02);
        report_and_stop();
    end
endmodule : swrb_top_tb
